// [verif/atsc_command_block_sva.sv]
// Port-level assertions for the shadow command block
`timescale 1ns/1ns
`default_nettype none
module atsc_command_block_chk
  import atsc_pkg::*;
#(
  parameter int NUM_PARAMS = 5
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PRI_SEL,
  input wire logic SEC_SEL,
  input wire logic [2:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire atsc_byte_t WDATA,
  input wire atsc_byte_t RDATA,
  input wire logic RVALID,
  input wire logic D2H_INTR,
  input wire logic H2D_FRAME,
  input wire atsc_byte_t H2D_COMMAND,
  input wire logic LBA_MODE,
  input wire logic TARGET_DRIVE_SELECT,
  input wire logic [3:0] HEAD_NUM,
  input wire logic LBA48_MODE,
  input wire logic [3:0] LBA_27_24,
  input wire logic INTR_PEND
);
  logic wr;
  logic rd;
  assign wr = (PRI_SEL | SEC_SEL) & WR_EN;
  assign rd = (PRI_SEL | SEC_SEL) & RD_EN;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  AST_RVALID: assert property (rd |=> RVALID) else $error("read not answered");
  AST_RSVD: assert property (rd && ADDR == 3'h6 |=> RDATA[7] && RDATA[5])
    else $error("reserved bits not fixed");
  AST_CMD: assert property (wr && ADDR == 3'h7 |=> H2D_FRAME && H2D_COMMAND == $past(WDATA))
    else $error("command frame missing");
  AST_NOCMD: assert property (!(wr && ADDR == 3'h7) |=> !H2D_FRAME)
    else $error("stray command frame");
  AST_LBA: assert property (wr && ADDR == 3'h6 |=> ##1 LBA_MODE == $past(WDATA[6], 2))
    else $error("mode bit wrong");
  AST_DEV: assert property (wr && ADDR == 3'h6 |=> ##1 TARGET_DRIVE_SELECT == $past(WDATA[4], 2))
    else $error("drive select wrong");
  AST_HEAD: assert property (wr && ADDR == 3'h6 && !WDATA[6] |=> ##1 HEAD_NUM == $past(WDATA[3:0], 2))
    else $error("head wrong");
  AST_LBA_HI: assert property (wr && ADDR == 3'h6 && WDATA[6] && !LBA48_MODE ##1 !LBA48_MODE
    |=> LBA_27_24 == $past(WDATA[3:0], 2))
    else $error("upper block address wrong");
  AST_INTR: assert property (D2H_INTR |=> INTR_PEND) else $error("interrupt lost");
endmodule
bind atsc_command_block atsc_command_block_chk #(.NUM_PARAMS(NUM_PARAMS)) i_chk (.CLK_SYS, .RST_N,
  .PRI_SEL, .SEC_SEL, .ADDR, .WR_EN, .RD_EN, .WDATA, .RDATA, .RVALID, .D2H_INTR, .H2D_FRAME,
  .H2D_COMMAND, .LBA_MODE, .TARGET_DRIVE_SELECT, .HEAD_NUM, .LBA48_MODE, .LBA_27_24, .INTR_PEND);
`default_nettype wire

// [verif/atsc_command_block_test.sv]
// Self-checking bench for the shadow command block
`timescale 1ns/1ns
`default_nettype none
module atsc_command_block_test;
  import atsc_pkg::*;
  logic clk = 0, rst_n = 0, pri = 0, sec = 0, we = 0, re = 0, l48 = 0, slow = 0;
  logic [2:0] adr = 3'h0;
  atsc_byte_t wd = 8'h00, rdat, cmd, feat, st, er, prm, c;
  logic rv, h2d, fr, intr, lba, drv, ip;
  logic [3:0] hd, lb;
  atsc_byte_t dhw [3] = '{8'hA3, 8'h5C, 8'h5C};
  logic dhm [3] = '{1'b0, 1'b0, 1'b1};
  int err_total = 0, total_checks = 0;
  atsc_command_block i_dut (.CLK_SYS(clk), .RST_N(rst_n), .PRI_SEL(pri), .SEC_SEL(sec),
    .ADDR(adr), .WR_EN(we), .RD_EN(re), .WDATA(wd), .RDATA(rdat), .RVALID(rv),
    .LBA48_MODE(l48), .D2H_FRAME(fr), .D2H_STATUS(st), .D2H_ERROR(er), .D2H_SECT_CNT(prm),
    .D2H_SECT_NUM(prm), .D2H_CYL_LOW(prm), .D2H_CYL_HIGH(prm), .D2H_DRV_HEAD(prm),
    .D2H_INTR(intr), .H2D_FRAME(h2d), .H2D_COMMAND(cmd), .H2D_FEATURES(feat), .LBA_MODE(lba),
    .TARGET_DRIVE_SELECT(drv), .HEAD_NUM(hd), .LBA_27_24(lb), .INTR_PEND(ip));
  atsc_drive_model i_drv (.clk(clk), .h2d_frame(h2d), .h2d_command(cmd), .slow(slow),
    .d2h_frame(fr), .d2h_intr(intr), .d2h_status(st), .d2h_error(er), .d2h_param(prm));
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Secondary window when w is set
  task automatic wr(logic w, logic [2:0] a, atsc_byte_t d);
    @(negedge clk);
    {sec, pri, adr, wd, we} = {w, !w, a, d, 1'b1};
    @(negedge clk);
    {we, pri, sec} = 3'b000;
  endtask
  task automatic rd(logic [2:0] a, atsc_byte_t e, string n);
    @(negedge clk);
    {pri, adr, re} = {1'b1, a, 1'b1};
    @(negedge clk);
    {re, pri} = 2'b00;
    chk("rvalid", {7'h00, rv}, 8'h01);
    chk(n, rdat, e);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    rd(3'h6, 8'hA0, "dh_reset");
    for (int i = 2; i < 6; i++) wr(i[0], i[2:0], 8'(8'h11 * i));
    for (int i = 2; i < 6; i++) rd(i[2:0], 8'(8'h11 * i), "param");
    $display("param test done");
    foreach (dhw[k]) begin
      l48 = dhm[k];
      wr(k[0], 3'h6, dhw[k]);
      @(negedge clk);
      chk("lba", {7'h00, lba}, {7'h00, dhw[k][6]});
      chk("drv", {7'h00, drv}, {7'h00, dhw[k][4]});
      chk("head", {4'h0, hd}, dhw[k][6] ? 8'h00 : {4'h0, dhw[k][3:0]});
      chk("lba_hi", {4'h0, lb}, dhw[k][6] && !l48 ? {4'h0, dhw[k][3:0]} : 8'h00);
      rd(3'h6, dhw[k] | 8'hA0, "dh");
    end
    $display("drive head test done");
    wr(1'b0, 3'h1, 8'h3C);
    rd(3'h1, 8'h00, "err");
    for (int s = 1; s >= 0; s--) begin
      slow = s[0];
      c = s ? 8'hEC : 8'h20;
      wr(1'b0, 3'h7, c);
      chk("feat", feat, 8'h3C);
      chk("cmd", cmd, c);
      if (s == 1) rd(3'h7, 8'h80, "busy");
      for (int i = 0; i < 40 && ip !== 1'b1; i++) @(negedge clk);
      chk("intr", {7'h00, ip}, 8'h01);
      if (ip !== 1'b1) test_done();
      rd(3'h7, 8'h50, "status");
      chk("intr_clr", {7'h00, ip}, 8'h00);
      rd(3'h1, 8'h04, "err");
      rd(3'h2, c, "count");
    end
    $display("command test done");
    test_done();
  end
endmodule
`default_nettype wire

// [verif/atsc_drive_model.sv]
// Drive-side partner that answers command frames after a delay
`timescale 1ns/1ns
`default_nettype none
module atsc_drive_model
  import atsc_pkg::*;
(
  input wire logic clk,
  input wire logic h2d_frame,
  input wire atsc_byte_t h2d_command,
  input wire logic slow,
  output logic d2h_frame,
  output logic d2h_intr,
  output atsc_byte_t d2h_status,
  output atsc_byte_t d2h_error,
  output atsc_byte_t d2h_param
);
  int cnt = 0;
  atsc_byte_t held = 8'h00;
  initial {d2h_frame, d2h_intr, d2h_status, d2h_error, d2h_param} = '0;
  always @(posedge clk) begin
    cnt <= h2d_frame ? (slow ? 20 : 2) : (cnt > 0 ? cnt - 1 : 0);
    if (h2d_frame) held <= h2d_command;
    d2h_frame <= cnt == 1;
    d2h_intr <= cnt == 1;
    // Idle lines toggle so a stale byte cannot pass for a live one
    d2h_status <= cnt == 1 ? 8'h50 : ~d2h_status;
    d2h_error <= cnt == 1 ? 8'h04 : ~d2h_error;
    d2h_param <= cnt == 1 ? held : ~d2h_param;
  end
endmodule
`default_nettype wire

// [verilog/atsc_byte_reg.sv]
// One byte of parameter storage with write strobe and device-side load
`timescale 1ns/1ns
`default_nettype none
`include "atsc_params.svh"
module atsc_byte_reg
  import atsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_we,
  input wire atsc_byte_t host_data,
  input wire logic dev_we,
  input wire atsc_byte_t dev_data,
  output atsc_byte_t value
);
  // Host write takes priority over a device load in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value <= `ATSC_RST_PARAM;
    end else if (host_we) begin
      value <= host_data;
    end else if (dev_we) begin
      value <= dev_data;
    end
  end
endmodule
`default_nettype wire

// [verilog/atsc_command_block.sv]
// Shadow task-file command block of the IDE-mode register window
`timescale 1ns/1ns
`default_nettype none
`include "atsc_params.svh"
module atsc_command_block
  import atsc_pkg::*;
#(
  parameter int NUM_PARAMS = 5
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register access from the base address decoders
  input wire logic PRI_SEL,
  input wire logic SEC_SEL,
  input wire logic [2:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire atsc_byte_t WDATA,
  output atsc_byte_t RDATA,
  output logic RVALID,
  // Mode qualifier for the low nibble
  input wire logic LBA48_MODE,
  // Drive-side frame interface
  input wire logic D2H_FRAME,
  input wire atsc_byte_t D2H_STATUS,
  input wire atsc_byte_t D2H_ERROR,
  input wire atsc_byte_t D2H_SECT_CNT,
  input wire atsc_byte_t D2H_SECT_NUM,
  input wire atsc_byte_t D2H_CYL_LOW,
  input wire atsc_byte_t D2H_CYL_HIGH,
  input wire atsc_byte_t D2H_DRV_HEAD,
  input wire logic D2H_INTR,
  output logic H2D_FRAME,
  output atsc_byte_t H2D_COMMAND,
  output atsc_byte_t H2D_FEATURES,
  // Decoded drive/head fields and interrupt pending flag
  output logic LBA_MODE,
  output logic TARGET_DRIVE_SELECT,
  output logic [3:0] HEAD_NUM,
  output logic [3:0] LBA_27_24,
  output logic INTR_PEND
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic sel = PRI_SEL | SEC_SEL;
  wire logic wr = sel & WR_EN;
  wire logic rd = sel & RD_EN;
  wire logic wr_feat = wr && (ADDR == `ATSC_OFS_ERR_FEAT);
  wire logic wr_dh = wr && (ADDR == `ATSC_OFS_DRV_HEAD);
  wire logic wr_cmd = wr && (ADDR == `ATSC_OFS_STAT_CMD);
  wire logic rd_stat = rd && (ADDR == `ATSC_OFS_STAT_CMD);

  // ----------------------------------------
  // Parameter storage
  // ----------------------------------------
  atsc_byte_t feature_param_reg;
  atsc_byte_t command_error_reg;
  atsc_byte_t command_status_reg;
  atsc_byte_t drive_select_and_head;
  atsc_byte_t param_val [NUM_PARAMS];
  atsc_byte_t d2h_val [NUM_PARAMS];
  logic [NUM_PARAMS-1:0] param_we;
  localparam logic [2:0] PARAM_BASE = `ATSC_OFS_SECT_CNT;

  assign d2h_val[0] = D2H_SECT_CNT;
  assign d2h_val[1] = D2H_SECT_NUM;
  assign d2h_val[2] = D2H_CYL_LOW;
  assign d2h_val[3] = D2H_CYL_HIGH;
  assign d2h_val[4] = D2H_DRV_HEAD;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PARAMS; gi++) begin : g_param
      assign param_we[gi] = wr && (ADDR == PARAM_BASE + 3'(gi));
      atsc_byte_reg u_reg (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .host_we(param_we[gi]),
        .host_data(WDATA),
        .dev_we(D2H_FRAME),
        .dev_data(d2h_val[gi]),
        .value(param_val[gi])
      );
    end
  endgenerate

  // reserved bits forced; stored copies never matter
  always_comb begin
    drive_select_and_head = param_val[4];
    drive_select_and_head[`ATSC_DH_RSVD_HI] = `ATSC_DH_RSVD_VAL;
    drive_select_and_head[`ATSC_DH_RSVD_LO] = `ATSC_DH_RSVD_VAL;
  end

  // ----------------------------------------
  // Features, error, status and command
  // ----------------------------------------
  // features storage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      feature_param_reg <= `ATSC_RST_PARAM;
    end else if (wr_feat) begin
      feature_param_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      command_error_reg <= `ATSC_RST_PARAM;
    end else if (D2H_FRAME) begin
      command_error_reg <= D2H_ERROR;
    end
  end

  atsc_byte_t next_status;
  always_comb begin
    next_status = command_status_reg;
    if (D2H_FRAME) begin
      next_status = D2H_STATUS;
    end
    if (wr_cmd) begin
      next_status[`ATSC_ST_BSY] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      command_status_reg <= `ATSC_RST_STATUS;
      H2D_FRAME <= 1'b0;
      H2D_COMMAND <= `ATSC_RST_PARAM;
      H2D_FEATURES <= `ATSC_RST_PARAM;
    end else begin
      command_status_reg <= next_status;
      H2D_FRAME <= wr_cmd;
      if (wr_cmd) begin
        H2D_COMMAND <= WDATA;
        H2D_FEATURES <= feature_param_reg;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      INTR_PEND <= 1'b0;
    end else if (D2H_INTR) begin
      INTR_PEND <= 1'b1;
    end else if (rd_stat) begin
      INTR_PEND <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  atsc_byte_t rd_mux;
  always_comb begin
    case (ADDR)
      `ATSC_OFS_ERR_FEAT: rd_mux = command_error_reg;
      `ATSC_OFS_SECT_CNT: rd_mux = param_val[0];
      `ATSC_OFS_SECT_NUM: rd_mux = param_val[1];
      `ATSC_OFS_CYL_LOW: rd_mux = param_val[2];
      `ATSC_OFS_CYL_HIGH: rd_mux = param_val[3];
      `ATSC_OFS_DRV_HEAD: rd_mux = drive_select_and_head;
      `ATSC_OFS_STAT_CMD: rd_mux = command_status_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end else begin
      RVALID <= rd;
      if (rd) begin
        RDATA <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Drive/head field decode
  // ----------------------------------------
  atsc_mode_e mode;
  always_comb begin
    // Addressing mode from bit 6 and the 48-bit qualifier
    if (!drive_select_and_head[`ATSC_DH_LBA]) begin
      mode = ATSC_CHS;
    end else if (LBA48_MODE) begin
      mode = ATSC_LBA48;
    end else begin
      mode = ATSC_LBA28;
    end
  end

  wire logic [3:0] nib = drive_select_and_head[`ATSC_DH_HEAD_MSB:0];

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      LBA_MODE <= 1'b0;
      TARGET_DRIVE_SELECT <= 1'b0;
      HEAD_NUM <= 4'h0;
      LBA_27_24 <= 4'h0;
    end else begin
      LBA_MODE <= drive_select_and_head[`ATSC_DH_LBA];
      TARGET_DRIVE_SELECT <= drive_select_and_head[`ATSC_DH_DEV];
      case (mode)
        ATSC_CHS: begin
          HEAD_NUM <= nib;
          LBA_27_24 <= 4'h0;
        end
        ATSC_LBA28: begin
          HEAD_NUM <= 4'h0;
          LBA_27_24 <= nib;
        end
        default: begin
          HEAD_NUM <= 4'h0;
          LBA_27_24 <= 4'h0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [verilog/atsc_params.svh]
// Offsets, field positions and reset values of the shadow command block
`ifndef ATSC_PARAMS_SVH
`define ATSC_PARAMS_SVH

// ----------------------------------------
// Register offsets in the command block window
// ----------------------------------------
`define ATSC_OFS_DATA 3'h0
`define ATSC_OFS_ERR_FEAT 3'h1
`define ATSC_OFS_SECT_CNT 3'h2
`define ATSC_OFS_SECT_NUM 3'h3
`define ATSC_OFS_CYL_LOW 3'h4
`define ATSC_OFS_CYL_HIGH 3'h5
`define ATSC_OFS_DRV_HEAD 3'h6
`define ATSC_OFS_STAT_CMD 3'h7

// ----------------------------------------
// Drive select and head fields
// ----------------------------------------
`define ATSC_DH_RSVD_HI 7
`define ATSC_DH_LBA 6
`define ATSC_DH_RSVD_LO 5
`define ATSC_DH_DEV 4
`define ATSC_DH_HEAD_MSB 3
`define ATSC_DH_RSVD_VAL 1'b1

// ----------------------------------------
// Status fields and reset values
// ----------------------------------------
`define ATSC_ST_BSY 7
`define ATSC_RST_PARAM 8'h00
`define ATSC_RST_STATUS 8'h00

`endif

// [verilog/atsc_pkg.sv]
// Types shared by the shadow command block
package atsc_pkg;
  typedef logic [7:0] atsc_byte_t;
  typedef enum logic [1:0] {
    ATSC_CHS,
    ATSC_LBA28,
    ATSC_LBA48
  } atsc_mode_e;
endpackage
